/* File: hw/single_wire_uart_slave_port.sv */
// Slave end of the shared single-wire datagram link
// Functional notes
// - Datagrams open with sync byte, then address
// - Bytes framed by low start, high stop
// - Bit time measured from sync, every datagram
// - Write datagram is eight bytes with data
// - Node address taken from two strap pins
// - Register byte bit 7 selects write
// - Over 63 bit gap resets reception
// - Twelve idle bit times before new traffic
// - Short idle-line pulse is a glitch
// - Bad check byte recovers like glitch
// - Accepted writes bump wrapping 8-bit counter
// - Line idles high; idle line gives pin power-down unless disabled
// - Read request is four bytes, no data
// - Reply uses the request's baud rate
// - Reply waits eight-bit-time gap steps
// - Reply carries sync, 0xFF, address, data, check
// - Driver released four bit times after reply
// - Reserved sync bits enter check, ignored otherwise
// - Check byte is CRC-8 poly 0x07 LSB-first
// - Act only on good datagrams for us
`timescale 1ns/1ns
`default_nettype none
module single_wire_uart_slave_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic line_in,
	output logic line_out,
	output logic line_oe,
	input wire logic addr_strap_lo,
	input wire logic addr_strap_hi,
	input wire logic pdn_disable,
	input wire logic [3:0] reply_gap_setting,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [6:0] wr_addr,
	output logic [31:0] wr_data,
	output logic rd_req,
	output logic [6:0] rd_addr,
	input wire logic [31:0] rd_data,
	output logic [7:0] write_count,
	output logic [1:0] node_select_code,
	output logic comm_error,
	output logic pin_power_down
);
	typedef struct packed {
		logic [2:0] pin_a;
		logic [2:0] pin_b;
		logic line_prev;
		swire_pkg::state_t state;
		logic [15:0] bit_cur;
		logic [15:0] bit_ok;
		logic [15:0] cnt;
		logic [15:0] ok_cnt;
		logic [15:0] meas;
		logic [1:0] falls;
		logic [3:0] bitn;
		logic [2:0] bidx;
		logic [7:0] sh;
		logic [7:0] crc;
		logic [6:0] okn;
		logic [6:0] txn;
		logic [6:0] raddr;
		logic rw;
		logic match;
		logic [31:0] word;
		logic line_out;
		logic line_oe;
		logic [7:0] wcount;
		logic err;
		logic pdn;
	} regs_t;

	regs_t s;
	regs_t next_s;
	logic line;
	logic fall;
	logic rise;
	logic tick;
	logic tick_ok;
	logic byte_done;
	logic last;
	logic crc_good;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [6:0] gap_bits;
	logic [7:0] tx_byte;
	logic [38:0] wr_bundle;

	// Serial CRC-8, bits taken LSB first
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[7] ^ b[i]) begin
				r = {r[6:0], 1'b0} ^ swire_pkg::CRC_POLY;
			end else begin
				r = {r[6:0], 1'b0};
			end
		end
		return r;
	endfunction

	// Reply byte by position; high data byte goes first
	function automatic logic [7:0] reply_byte(input logic [2:0] idx, input logic [6:0] ra,
		input logic [31:0] w, input logic [7:0] c);
		case (idx)
			3'h0: reply_byte = {4'h0, swire_pkg::SYNC_NIBBLE};
			3'h1: reply_byte = swire_pkg::REPLY_ADDR;
			3'h2: reply_byte = {1'b0, ra};
			3'h3: reply_byte = w[31:24];
			3'h4: reply_byte = w[23:16];
			3'h5: reply_byte = w[15:8];
			3'h6: reply_byte = w[7:0];
			default: reply_byte = c;
		endcase
	endfunction

	assign line = s.pin_b[0];
	assign fall = s.line_prev && !line;
	assign rise = !s.line_prev && line;
	assign tick = s.cnt >= s.bit_cur - 16'h0001;
	assign tick_ok = s.ok_cnt >= s.bit_ok - 16'h0001;
	assign gap_bits = {(reply_gap_setting == 4'h0) ? swire_pkg::GAP_DEFAULT : reply_gap_setting, 3'h0};
	assign byte_done = s.state == swire_pkg::ST_RX && tick && s.bitn == swire_pkg::STOP_BIT && line;
	assign last = (s.bidx == swire_pkg::READ_LAST && !s.rw) || s.bidx == swire_pkg::WRITE_LAST;
	assign crc_good = s.sh == s.crc;
	assign rd_req = byte_done && last && crc_good && s.match && !s.rw;
	assign fifo_in_valid = s.state == swire_pkg::ST_PUSH;
	assign tx_byte = reply_byte(s.bidx, s.raddr, s.word, s.crc);

	assign line_out = s.line_out;
	assign line_oe = s.line_oe;
	assign rd_addr = s.raddr;
	assign write_count = s.wcount;
	assign node_select_code = s.pin_b[2:1];
	assign comm_error = s.err;
	assign pin_power_down = s.pdn;
	assign wr_addr = wr_bundle[38:32];
	assign wr_data = wr_bundle[31:0];

	always_comb begin
		logic recover;
		recover = 1'b0;
		next_s = s;
		next_s.pin_a = {addr_strap_hi, addr_strap_lo, line_in};
		next_s.pin_b = s.pin_a;
		next_s.line_prev = s.pin_b[0];
		next_s.cnt = tick ? 16'h0000 : s.cnt + 16'h0001;
		next_s.ok_cnt = tick_ok ? 16'h0000 : s.ok_cnt + 16'h0001;
		next_s.err = 1'b0;
		// Pin power-down only while the interface has not disabled it
		next_s.pdn = !pdn_disable && s.pin_b[0];
		if (tick_ok && s.okn != swire_pkg::COUNT_MAX) begin
			next_s.okn = s.okn + 7'h01;
		end
		if (tick && s.txn != swire_pkg::COUNT_MAX) begin
			next_s.txn = s.txn + 7'h01;
		end
		case (s.state)
			swire_pkg::ST_IDLE: begin
				if (fall) begin
					next_s.state = swire_pkg::ST_SYNC;
					next_s.meas = 16'h0001;
					next_s.falls = 2'h1;
					next_s.okn = '0;
					next_s.ok_cnt = '0;
					next_s.bidx = '0;
					next_s.crc = '0;
					next_s.rw = 1'b0;
					next_s.match = 1'b0;
				end
			end
			swire_pkg::ST_SYNC: begin
				next_s.meas = s.meas + 16'h0001;
				if (rise && s.falls == 2'h1 && s.meas < swire_pkg::GLITCH_CYCLES) begin
					recover = 1'b1;
				end else if (s.meas == swire_pkg::MEAS_LIMIT) begin
					recover = 1'b1;
				end else if (fall) begin
					if (s.falls == 2'h2) begin
						// Third fall ends sync bit 2: four bit times measured
						next_s.bit_cur = s.meas >> swire_pkg::SYNC_SHIFT;
						next_s.cnt = s.meas >> (swire_pkg::SYNC_SHIFT + 1);
						next_s.bitn = swire_pkg::SYNC_RESUME_BIT;
						next_s.sh = swire_pkg::SYNC_PRELOAD;
						next_s.state = swire_pkg::ST_RX;
						if ((s.meas >> swire_pkg::SYNC_SHIFT) < swire_pkg::MIN_BIT_CYCLES) begin
							recover = 1'b1;
						end
					end else begin
						next_s.falls = s.falls + 2'h1;
					end
				end
			end
			swire_pkg::ST_RX: begin
				if (tick) begin
					if (s.bitn == 4'h0) begin
						if (line) begin
							recover = 1'b1;
						end else begin
							next_s.bitn = 4'h1;
						end
					end else if (s.bitn != swire_pkg::STOP_BIT) begin
						next_s.sh = {line, s.sh[7:1]};
						next_s.bitn = s.bitn + 4'h1;
					end else if (!line) begin
						recover = 1'b1;
					end else if (!last) begin
						// Reserved sync bits are only hashed, never checked
						next_s.crc = crc8(s.crc, s.sh);
						next_s.bidx = s.bidx + 3'h1;
						next_s.state = swire_pkg::ST_WAIT;
						if (s.bidx == 3'h1) begin
							next_s.match = s.sh == {6'h00, s.pin_b[2:1]};
						end
						if (s.bidx == 3'h2) begin
							next_s.rw = s.sh[7];
							next_s.raddr = s.sh[6:0];
						end
						if (s.bidx >= 3'h3) begin
							next_s.word = {s.word[23:0], s.sh};
						end
					end else if (!crc_good) begin
						recover = 1'b1;
					end else if (!s.match) begin
						next_s.state = swire_pkg::ST_IDLE;
					end else begin
						next_s.bit_ok = s.bit_cur;
						next_s.ok_cnt = '0;
						if (s.rw) begin
							next_s.state = swire_pkg::ST_PUSH;
						end else begin
							next_s.word = rd_data;
							next_s.state = swire_pkg::ST_GAP;
							next_s.cnt = '0;
							next_s.txn = '0;
						end
					end
				end
			end
			swire_pkg::ST_WAIT: begin
				if (fall) begin
					next_s.state = swire_pkg::ST_RX;
					next_s.cnt = s.bit_cur >> 1;
					next_s.bitn = 4'h0;
					next_s.okn = '0;
					next_s.ok_cnt = '0;
				end else if (s.okn > swire_pkg::TIMEOUT_BITS) begin
					recover = 1'b1;
				end
			end
			swire_pkg::ST_RECOVER: begin
				if (!line) begin
					next_s.okn = '0;
					next_s.ok_cnt = '0;
				end else if (s.okn >= swire_pkg::RECOVER_BITS) begin
					next_s.state = swire_pkg::ST_IDLE;
				end
			end
			swire_pkg::ST_PUSH: begin
				// Waits here while the FIFO is full; the line is ignored meanwhile
				if (fifo_in_ready) begin
					next_s.wcount = s.wcount + 8'h01;
					next_s.state = swire_pkg::ST_IDLE;
				end
			end
			swire_pkg::ST_GAP: begin
				if (s.txn >= gap_bits) begin
					next_s.state = swire_pkg::ST_SEND;
					next_s.line_oe = 1'b1;
					next_s.line_out = 1'b0;
					next_s.bitn = 4'h0;
					next_s.bidx = 3'h0;
					next_s.crc = '0;
					next_s.cnt = '0;
				end
			end
			swire_pkg::ST_SEND: begin
				if (tick) begin
					if (s.bitn == swire_pkg::STOP_BIT) begin
						next_s.crc = crc8(s.crc, tx_byte);
						if (s.bidx == swire_pkg::WRITE_LAST) begin
							next_s.state = swire_pkg::ST_HOLD;
							next_s.txn = '0;
						end else begin
							next_s.bidx = s.bidx + 3'h1;
							next_s.bitn = 4'h0;
							next_s.line_out = 1'b0;
						end
					end else begin
						next_s.bitn = s.bitn + 4'h1;
						next_s.line_out = (s.bitn == swire_pkg::STOP_BIT - 4'h1) ? 1'b1 : tx_byte[s.bitn[2:0]];
					end
				end
			end
			swire_pkg::ST_HOLD: begin
				next_s.line_out = 1'b1;
				if (s.txn >= swire_pkg::RELEASE_BITS) begin
					next_s.line_oe = 1'b0;
					next_s.state = swire_pkg::ST_IDLE;
				end
			end
			default: begin
				next_s.state = swire_pkg::ST_IDLE;
			end
		endcase
		if (recover) begin
			next_s.state = swire_pkg::ST_RECOVER;
			next_s.okn = '0;
			next_s.ok_cnt = '0;
			next_s.err = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
			s.pin_a <= swire_pkg::PIN_RESET;
			s.pin_b <= swire_pkg::PIN_RESET;
			s.line_prev <= 1'b1;
			s.state <= swire_pkg::ST_IDLE;
			s.bit_cur <= swire_pkg::BIT_RESET;
			s.bit_ok <= swire_pkg::BIT_RESET;
			s.line_out <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	swire_fifo #(
		.WIDTH(swire_pkg::FIFO_WIDTH),
		.DEPTH(swire_pkg::FIFO_DEPTH)
	) write_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data({s.raddr, s.word}),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(wr_bundle)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	count_step_a: assert property (
		s.state == swire_pkg::ST_PUSH && fifo_in_ready |=> s.wcount == $past(s.wcount) + 8'h01
	) else $error("write count did not advance");

	read_count_a: assert property (
		rd_req |=> $stable(s.wcount) && s.state == swire_pkg::ST_GAP
	) else $error("read request changed write count");

	crc_fail_a: assert property (
		byte_done && last && !crc_good |=> s.state == swire_pkg::ST_RECOVER && comm_error
	) else $error("bad check byte not recovered");

	glitch_rec_a: assert property (
		s.state == swire_pkg::ST_SYNC && rise && s.falls == 2'h1 && s.meas < swire_pkg::GLITCH_CYCLES
		|=> s.state == swire_pkg::ST_RECOVER
	) else $error("glitch not recovered");

	gap_timeout_a: assert property (
		s.state == swire_pkg::ST_WAIT && !fall && s.okn > swire_pkg::TIMEOUT_BITS
		|=> s.state == swire_pkg::ST_RECOVER
	) else $error("byte gap timeout missed");

	abort_quiet_a: assert property (
		s.state == swire_pkg::ST_RECOVER |-> !rd_req && !fifo_in_valid && !s.line_oe
	) else $error("aborted datagram had an effect");

	reply_gap_a: assert property (
		$rose(s.line_oe) |-> $past(s.state) == swire_pkg::ST_GAP && $past(s.txn) >= $past(gap_bits)
	) else $error("reply started before delay");

	driver_release_a: assert property (
		$fell(s.line_oe) |-> $past(s.state) == swire_pkg::ST_HOLD && $past(s.txn) == swire_pkg::RELEASE_BITS
	) else $error("driver released at wrong time");

	own_node_a: assert property (
		byte_done && s.bidx == 3'h1 |=> s.match == ($past(s.sh) == {6'h00, node_select_code})
	) else $error("node address compare wrong");

	master_addr_a: assert property (
		s.state == swire_pkg::ST_SEND && s.bidx == 3'h1 && s.bitn != 4'h0 |-> s.line_out
	) else $error("reply address byte not all ones");
endmodule
`default_nettype wire

/* File: hw/swire_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module swire_fifo #(
	parameter int WIDTH = swire_pkg::FIFO_WIDTH,
	parameter int DEPTH = swire_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
	} fifo_t;

	fifo_t s;
	fifo_t next_s;

	// Extra pointer bit tells full from empty
	assign in_ready = !(s.wr[AW] != s.rd[AW] && s.wr[AW-1:0] == s.rd[AW-1:0]);
	assign out_valid = s.wr != s.rd;
	assign out_data = s.mem[s.rd[AW-1:0]];

	always_comb begin
		next_s = s;
		if (in_valid && in_ready) begin
			next_s.mem[s.wr[AW-1:0]] = in_data;
			next_s.wr = s.wr + 1'b1;
		end
		if (out_valid && out_ready) begin
			next_s.rd = s.rd + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

/* File: hw/swire_pkg.sv */
// Constants, states and field layout of the single-wire datagram port
package swire_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int MIN_BAUD = 9000;
	localparam logic [15:0] BIT_RESET = 16'(CLK_HZ / MIN_BAUD);
	localparam logic [15:0] MIN_BIT_CYCLES = 16'h0010;
	localparam logic [15:0] GLITCH_CYCLES = 16'h0010;
	localparam logic [15:0] MEAS_LIMIT = 16'hFFFF;
	localparam int SYNC_SHIFT = 2;
	localparam logic [3:0] SYNC_NIBBLE = 4'h5;
	localparam logic [7:0] SYNC_PRELOAD = 8'hA0;
	localparam logic [3:0] SYNC_RESUME_BIT = 4'h4;
	localparam logic [3:0] STOP_BIT = 4'h9;
	localparam logic [2:0] READ_LAST = 3'h3;
	localparam logic [2:0] WRITE_LAST = 3'h7;
	localparam logic [7:0] REPLY_ADDR = 8'hFF;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [6:0] TIMEOUT_BITS = 7'h3F;
	localparam logic [6:0] RECOVER_BITS = 7'h0C;
	localparam logic [6:0] RELEASE_BITS = 7'h04;
	localparam logic [6:0] COUNT_MAX = 7'h7F;
	localparam logic [3:0] GAP_DEFAULT = 4'h1;
	localparam logic [2:0] PIN_RESET = 3'h7;
	localparam int FIFO_WIDTH = 39;
	localparam int FIFO_DEPTH = 32;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_SYNC = 9'h002,
		ST_RX = 9'h004,
		ST_WAIT = 9'h008,
		ST_RECOVER = 9'h010,
		ST_PUSH = 9'h020,
		ST_GAP = 9'h040,
		ST_SEND = 9'h080,
		ST_HOLD = 9'h100
	} state_t;
endpackage

/* File: testbench/single_wire_uart_slave_port_bench.sv */
// Self-checking bench for the single-wire datagram port
`timescale 1ns/1ns
`default_nettype none
module single_wire_uart_slave_port_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic host_tx, dut_out, dut_oe, strap_lo, strap_hi, pdn_disable, wr_valid;
	logic rd_req, comm_error, pin_power_down, rx_strobe;
	logic hold_ready = 1'b0;
	logic wr_ready = 1'b0;
	logic [3:0] gap;
	logic [6:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [7:0] write_count;
	logic [1:0] node_code, own;
	logic [8:0] rx_word;
	logic [38:0] wq[$], rq[$], aq[$], eq[$];
	int err_total = 0, compares = 0, cyc = 0, count_exp = 0;
	wire logic line = (dut_oe ? dut_out : 1'b1) & host_tx;
	single_wire_uart_slave_port single_wire_uart_slave_port_inst (.clk(clk), .rst_n(rst_n), .line_in(line),
		.line_out(dut_out), .line_oe(dut_oe), .addr_strap_lo(strap_lo), .addr_strap_hi(strap_hi),
		.pdn_disable(pdn_disable), .reply_gap_setting(gap), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
		.write_count(write_count), .node_select_code(node_code), .comm_error(comm_error),
		.pin_power_down(pin_power_down));
	swire_host swire_host_inst (.clk(clk), .line(line), .tx(host_tx), .rx_word(rx_word), .rx_strobe(rx_strobe));
	initial forever #50 clk = ~clk;
	task automatic end_of_test();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [38:0] exp, input logic [38:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic take(input string what, ref logic [38:0] q[$], input logic [38:0] got);
		if (q.size() == 0) begin
			compares++;
			err_total++;
			$display("BAD %s expected none seen %h", what, got);
		end else chk(what, q.pop_front(), got);
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] b[$]);
		logic [7:0] c = 8'h00;
		foreach (b[i]) for (int j = 0; j < 8; j++) c = (c[7] ^ b[i][j]) ? ((c << 1) ^ 8'h07) : (c << 1);
		return c;
	endfunction
	task automatic idle(input int bits);
		repeat (bits * swire_host_inst.bit_cycles) @(posedge clk);
	endtask
	task automatic send_dg(input logic [7:0] b[$], input logic bad);
		b.push_back(crc8(b) ^ {8{bad}});
		foreach (b[i]) swire_host_inst.send_byte(b[i]);
	endtask
	task automatic do_write(input logic [1:0] node, input logic bad);
		logic [6:0] a;
		logic [31:0] d;
		a = 7'($urandom);
		d = $urandom;
		if (!bad && node == own) begin
			wq.push_back({a, d});
			count_exp++;
		end
		if (bad) eq.push_back(39'h1);
		send_dg('{{4'($urandom), 4'h5}, {6'h00, node}, {1'b1, a}, d[31:24], d[23:16], d[15:8], d[7:0]}, bad);
	endtask
	task automatic do_read(input logic [1:0] node);
		logic [6:0] a;
		logic [31:0] d;
		logic [7:0] r[$];
		int n, g, b;
		a = 7'($urandom);
		d = $urandom;
		rd_data <= d;
		b = swire_host_inst.bit_cycles;
		r = '{8'h05, 8'hFF, {1'b0, a}, d[31:24], d[23:16], d[15:8], d[7:0]};
		r.push_back(crc8(r));
		if (node == own) begin
			foreach (r[i]) rq.push_back({30'h0, 1'b1, r[i]});
			aq.push_back({32'h0, a});
		end
		send_dg('{{4'($urandom), 4'h5}, {6'h00, node}, {1'b0, a}}, 1'b0);
		// Delay setting read only once a change made just before the call has landed
		g = (gap == 4'h0) ? 1 : int'(gap);
		n = 0;
		while (line === 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		if (node == own) chk("reply gap", 1, n >= 8 * g * b - b && n <= 8 * g * b + 6);
		while (rq.size() != 0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		idle(3);
		chk("driver held", node == own, dut_oe);
		idle(3);
		chk("driver off", 0, dut_oe);
	endtask
	always @(posedge clk) begin
		wr_ready <= hold_ready ? 1'b0 : 1'($urandom);
		if (wr_valid === 1'b1 && wr_ready === 1'b1) take("write word", wq, {wr_addr, wr_data});
		if (rx_strobe === 1'b1) take("reply byte", rq, {30'h0, rx_word});
		if (rd_req === 1'b1) take("read addr", aq, {32'h0, rd_addr});
		if (comm_error === 1'b1) take("comm error", eq, 39'h1);
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(67));
		own = 2'($urandom);
		strap_lo <= own[0];
		strap_hi <= own[1];
		pdn_disable <= 1'b0;
		gap <= 4'h1;
		rd_data <= 32'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		chk("node code", own, node_code);
		chk("pin power down", 1, pin_power_down);
		pdn_disable <= 1'b1;
		repeat (3) @(posedge clk);
		chk("pin power down", 0, pin_power_down);
		do_write(own, 1'b0);
		do_write(own, 1'b0);
		do_write(own ^ 2'h1, 1'b0);
		do_read(own);
		gap <= 4'h0;
		do_read(own);
		gap <= 4'h2;
		do_read(own ^ 2'h2);
		do_read(own);
		idle(20);
		do_write(own, 1'b1);
		idle(14);
		eq.push_back(39'h1);
		swire_host_inst.pulse(5);
		idle(14);
		eq.push_back(39'h1);
		send_dg('{8'h05, {6'h00, own}}, 1'b0);
		idle(84);
		// Faster rate, then fill the write buffer until it refuses
		swire_host_inst.bit_cycles = 16;
		hold_ready <= 1'b1;
		repeat (33) do_write(own, 1'b0);
		repeat (40) @(posedge clk);
		chk("count stalled", count_exp - 1, write_count);
		hold_ready <= 1'b0;
		while (wq.size() != 0 && cyc < 89000) @(posedge clk);
		repeat (4) @(posedge clk);
		chk("write count", count_exp, write_count);
		chk("leftover notes", 0, wq.size() + rq.size() + aq.size() + eq.size());
		end_of_test();
	end
endmodule
`default_nettype wire

/* File: testbench/swire_host.sv */
// Host UART model sharing the single data line
`timescale 1ns/1ns
`default_nettype none
module swire_host (
	input wire logic clk,
	input wire logic line,
	output logic tx,
	output logic [8:0] rx_word,
	output logic rx_strobe
);
	int bit_cycles = 20;
	logic sending = 1'b0;
	initial begin
		tx <= 1'b1;
	end
	task automatic hold_bit(input logic v);
		tx <= v;
		repeat (bit_cycles) @(posedge clk);
	endtask
	// Called at a rising edge; ends at the edge that closes the stop bit
	task automatic send_byte(input logic [7:0] b);
		sending = 1'b1;
		hold_bit(1'b0);
		for (int i = 0; i < 8; i++) hold_bit(b[i]);
		hold_bit(1'b1);
		sending = 1'b0;
	endtask
	task automatic pulse(input int n);
		sending = 1'b1;
		tx <= 1'b0;
		repeat (n) @(posedge clk);
		tx <= 1'b1;
		@(posedge clk);
		sending = 1'b0;
	endtask
	// Reply receiver at the host's own rate, stop bit kept in bit 8
	initial begin
		rx_word = 9'h000;
		rx_strobe = 1'b0;
		forever begin
			@(posedge clk);
			rx_strobe <= 1'b0;
			if (!sending && line === 1'b0) begin
				repeat (bit_cycles / 2) @(posedge clk);
				for (int i = 0; i < 9; i++) begin
					repeat (bit_cycles) @(posedge clk);
					rx_word[i] <= line;
				end
				rx_strobe <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire
